// *** hdl/trt_half8.sv ***
`timescale 1ns/10ps
`default_nettype none
module trt_half8 (
	input wire logic clk, // core clock
	input wire logic rst_n, // async reset, active low
	input wire logic inc, // advance by one this cycle
	input wire logic reloadOnWrap, // take reload value when wrapping
	input wire logic [7:0] reloadVal, // auto-reload byte
	input wire logic swWrite, // software writes the count
	input wire logic [7:0] swData, // software count value
	output logic [7:0] count, // current count
	output logic wrap // count goes past 0xff this cycle
);
	import trt_pkg::*;

	logic [7:0] count_reg;
	logic [7:0] count_next;
	wire logic [7:0] countInc = count_reg + 8'h01;

	assign wrap = inc && (count_reg == 8'hff);
	assign count_next = swWrite ? swData :
		!inc ? count_reg :
		(wrap && reloadOnWrap) ? reloadVal : countInc;
	assign count = count_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= TRT_BYTE_RST;
		end else begin
			count_reg <= count_next;
		end
	end
endmodule : trt_half8
`default_nettype wire

// *** hdl/trt_pkg.sv ***
package trt_pkg;
	// special function register addresses
	localparam logic [7:0] TRT_ADDR_TCTRL = 8'h88;
	localparam logic [7:0] TRT_ADDR_RCTRL = 8'hc8;
	localparam logic [7:0] TRT_ADDR_RLL = 8'hca;
	localparam logic [7:0] TRT_ADDR_RLH = 8'hcb;
	localparam logic [7:0] TRT_ADDR_CNTL = 8'hcc;
	localparam logic [7:0] TRT_ADDR_CNTH = 8'hcd;
	localparam logic [7:0] TRT_ADDR_CKCFG = 8'h8e;
	// timer_ext_irq_control bit positions
	localparam int TC_T1_OVF = 7;
	localparam int TC_T1_RUN = 6;
	localparam int TC_T0_OVF = 5;
	localparam int TC_T0_RUN = 4;
	localparam int TC_X1_FLAG = 3;
	localparam int TC_X1_TYPE = 2;
	localparam int TC_X0_FLAG = 1;
	localparam int TC_X0_TYPE = 0;
	// reload_timer_control bit positions
	localparam int RC_HIGH_OVF = 7;
	localparam int RC_LOW_OVF = 6;
	localparam int RC_LOW_IRQ_EN = 5;
	localparam int RC_SPLIT = 3;
	localparam int RC_RUN = 2;
	localparam int RC_EXT_TICK = 0;
	localparam logic [7:0] RC_WRITE_MASK = 8'hed;
	// timer_clock_config bit positions
	localparam int CK_HIGH_SEL = 5;
	localparam int CK_LOW_SEL = 4;
	localparam logic [7:0] CK_WRITE_MASK = 8'h30;
	// reset values
	localparam logic [7:0] TRT_TCTRL_RST = 8'h00;
	localparam logic [7:0] TRT_RCTRL_RST = 8'h00;
	localparam logic [7:0] TRT_CKCFG_RST = 8'h00;
	localparam logic [7:0] TRT_BYTE_RST = 8'h00;
	// prescaler: core clock divided by twelve
	localparam int TRT_DIV12 = 12;
	localparam logic [3:0] TRT_DIV12_LAST = 4'(TRT_DIV12 - 1);

	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic [7:0] wdata;
	} trt_sfr_t;

	// acknowledges that the core is vectoring to a handler
	typedef struct packed {
		logic timer1;
		logic timer0;
		logic ext1;
		logic ext0;
	} trt_vec_t;
endpackage : trt_pkg

// *** hdl/trt_timer_ctrl.sv ***
// Summary of operation
// - timer one overflow sets flag, cleared by vector
// - timer zero overflow sets flag, cleared by vector
// - ext one type: zero level, one edge
// - ext one flag set; vector clears if edge
// - ext zero type: zero level, one edge
// - ext zero flag set; vector clears if edge
// - split bit picks 16-bit or two 8-bit
// - clock: core, core/12, or external/8
// - external tick synchronised before use
// - 16-bit wrap reloads pair, sets high flag
// - interrupt on every 16-bit overflow when enabled
// - low byte wrap interrupts when also enabled
// - split halves reload from own reload byte
// - split: run gates high only, low free
// - split: each half selects core or chosen clock; 16-bit: low select only
`timescale 1ns/10ps
`default_nettype none
module trt_timer_ctrl (
	input wire logic clk, // core clock, 10 MHz
	input wire logic rst_n, // async reset, active low
	input wire trt_pkg::trt_sfr_t sfr, // register access port
	output logic [7:0] sfrRdata, // read data of last cycle's address
	input wire logic timer0Ovf, // timer zero overflow pulse
	input wire logic timer1Ovf, // timer one overflow pulse
	input wire trt_pkg::trt_vec_t vecAck, // handler vector pulses
	input wire logic extIrq0Input, // ext zero, already polarity adjusted
	input wire logic extIrq1Input, // ext one, already polarity adjusted
	input wire logic extOscDiv8, // external oscillator divided by 8
	input wire logic reloadTimerIrqEn, // interrupt enable for reload timer
	output logic timer0RunOut, // timer zero run enable
	output logic timer1RunOut, // timer one run enable
	output logic [7:0] tctrlOut, // timer_ext_irq_control contents
	output logic reloadTimerIrq // reload timer interrupt request
);
	import trt_pkg::*;

	logic [7:0] tctrl_reg;
	logic [7:0] tctrl_next;
	logic [7:0] rctrl_reg;
	logic [7:0] rctrl_next;
	logic [7:0] ckcfg_reg;
	logic [7:0] reloadLow_reg;
	logic [7:0] reloadHigh_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic irq_reg;
	logic [3:0] div12_reg;
	logic [2:0] extSync_reg;
	logic [1:0] extIn_reg;
	logic [7:0] countLow;
	logic [7:0] countHigh;
	logic lowWrap;
	logic highWrap;

	function automatic logic hit(input trt_sfr_t s, input logic [7:0] a);
		hit = s.write && (s.addr == a);
	endfunction : hit

	wire logic wrTctrl = hit(sfr, TRT_ADDR_TCTRL);
	wire logic wrRctrl = hit(sfr, TRT_ADDR_RCTRL);
	wire logic wrCkcfg = hit(sfr, TRT_ADDR_CKCFG);
	wire logic wrRll = hit(sfr, TRT_ADDR_RLL);
	wire logic wrRlh = hit(sfr, TRT_ADDR_RLH);
	wire logic wrCntL = hit(sfr, TRT_ADDR_CNTL);
	wire logic wrCntH = hit(sfr, TRT_ADDR_CNTH);

	// base value: a write replaces the byte (rctrl only its RC_WRITE_MASK bits), else it holds
	wire logic [7:0] tcBase = wrTctrl ? sfr.wdata : tctrl_reg;
	wire logic [7:0] rcBase = wrRctrl ?
		((sfr.wdata & RC_WRITE_MASK) | (rctrl_reg & ~RC_WRITE_MASK)) : rctrl_reg;

	// external inputs: edge mode looks at a rising edge, level mode at the level
	wire logic ext0Edge = extIrq0Input && !extIn_reg[0];
	wire logic ext1Edge = extIrq1Input && !extIn_reg[1];
	wire logic ext0Type = tctrl_reg[TC_X0_TYPE];
	wire logic ext1Type = tctrl_reg[TC_X1_TYPE];
	wire logic ext0Set = ext0Type ? ext0Edge : extIrq0Input;
	wire logic ext1Set = ext1Type ? ext1Edge : extIrq1Input;
	// level mode flags are only cleared by software, not by vectoring
	wire logic ext0VecClr = vecAck.ext0 && ext0Type;
	wire logic ext1VecClr = vecAck.ext1 && ext1Type;

	// hardware sets win over any clear in the same cycle
	always_comb begin
		tctrl_next = tcBase;
		tctrl_next[TC_T1_OVF] = timer1Ovf || (tcBase[TC_T1_OVF] && !vecAck.timer1);
		tctrl_next[TC_T0_OVF] = timer0Ovf || (tcBase[TC_T0_OVF] && !vecAck.timer0);
		tctrl_next[TC_X1_FLAG] = ext1Set || (tcBase[TC_X1_FLAG] && !ext1VecClr);
		tctrl_next[TC_X0_FLAG] = ext0Set || (tcBase[TC_X0_FLAG] && !ext0VecClr);
	end

	// clock sources: core clock, core/12 and the synchronised external tick
	wire logic div12Tick = (div12_reg == TRT_DIV12_LAST);
	// stage 0 feeds only stage 1; edges are taken between stages 1 and 2
	wire logic extTick = extSync_reg[1] && !extSync_reg[2];
	wire logic chosenTick = rctrl_reg[RC_EXT_TICK] ? extTick : div12Tick;
	wire logic lowTick = ckcfg_reg[CK_LOW_SEL] ? 1'b1 : chosenTick;
	wire logic highTick = ckcfg_reg[CK_HIGH_SEL] ? 1'b1 : chosenTick;

	wire logic splitMode = rctrl_reg[RC_SPLIT];
	wire logic runBit = rctrl_reg[RC_RUN];
	// 16-bit: low half paced by its clock and run bit, high half carried from low
	wire logic lowInc = splitMode ? lowTick : (lowTick && runBit);
	wire logic highInc = splitMode ? (highTick && runBit) : lowWrap;
	// 16-bit: low half reloads only when the whole count wraps
	wire logic lowReload = splitMode || (countHigh == 8'hff);

	trt_half8 lowHalf (
		.clk(clk),
		.rst_n(rst_n),
		.inc(lowInc),
		.reloadOnWrap(lowReload),
		.reloadVal(reloadLow_reg),
		.swWrite(wrCntL),
		.swData(sfr.wdata),
		.count(countLow),
		.wrap(lowWrap)
	);

	trt_half8 highHalf (
		.clk(clk),
		.rst_n(rst_n),
		.inc(highInc),
		.reloadOnWrap(1'b1),
		.reloadVal(reloadHigh_reg),
		.swWrite(wrCntH),
		.swData(sfr.wdata),
		.count(countHigh),
		.wrap(highWrap)
	);

	always_comb begin
		rctrl_next = rcBase;
		rctrl_next[RC_HIGH_OVF] = highWrap || rcBase[RC_HIGH_OVF];
		rctrl_next[RC_LOW_OVF] = lowWrap || rcBase[RC_LOW_OVF];
	end

	// request stays up while a flag it covers is set and enabled
	wire logic irqNext = reloadTimerIrqEn && (rctrl_next[RC_HIGH_OVF] ||
		(rctrl_next[RC_LOW_IRQ_EN] && rctrl_next[RC_LOW_OVF]));

	always_comb begin
		unique case (sfr.addr)
			TRT_ADDR_TCTRL: rdata_next = tctrl_reg;
			TRT_ADDR_RCTRL: rdata_next = rctrl_reg;
			TRT_ADDR_CKCFG: rdata_next = ckcfg_reg;
			TRT_ADDR_RLL: rdata_next = reloadLow_reg;
			TRT_ADDR_RLH: rdata_next = reloadHigh_reg;
			TRT_ADDR_CNTL: rdata_next = countLow;
			TRT_ADDR_CNTH: rdata_next = countHigh;
			default: rdata_next = 8'h00;
		endcase
	end

	// clock config keeps only the two half selects; other bits read back as zero
	wire logic [7:0] ckcfgNext = wrCkcfg ? (sfr.wdata & CK_WRITE_MASK) : ckcfg_reg;
	// reload bytes take effect at the next wrap, never mid-count
	wire logic [7:0] reloadLowNext = wrRll ? sfr.wdata : reloadLow_reg;
	wire logic [7:0] reloadHighNext = wrRlh ? sfr.wdata : reloadHigh_reg;

	// control bytes: flags and software writes are merged in the next-value logic
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tctrl_reg <= TRT_TCTRL_RST;
			rctrl_reg <= TRT_RCTRL_RST;
		end else begin
			tctrl_reg <= tctrl_next;
			rctrl_reg <= rctrl_next;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ckcfg_reg <= TRT_CKCFG_RST;
			reloadLow_reg <= TRT_BYTE_RST;
			reloadHigh_reg <= TRT_BYTE_RST;
		end else begin
			ckcfg_reg <= ckcfgNext;
			reloadLow_reg <= reloadLowNext;
			reloadHigh_reg <= reloadHighNext;
		end
	end

	// read data and request are registered so every output leaves a flip-flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= TRT_BYTE_RST;
			irq_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			irq_reg <= irqNext;
		end
	end

	// previous input levels for edge detection; reset matches the idle low level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			extIn_reg <= 2'b00;
		end else begin
			extIn_reg <= {extIrq1Input, extIrq0Input};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div12_reg <= 4'h0;
			extSync_reg <= 3'h0;
		end else begin
			div12_reg <= div12Tick ? 4'h0 : div12_reg + 4'h1;
			extSync_reg <= {extSync_reg[1:0], extOscDiv8};
		end
	end

	assign sfrRdata = rdata_reg;
	assign tctrlOut = tctrl_reg;
	assign timer0RunOut = tctrl_reg[TC_T0_RUN];
	assign timer1RunOut = tctrl_reg[TC_T1_RUN];
	assign reloadTimerIrq = irq_reg;
endmodule : trt_timer_ctrl
`default_nettype wire

// *** testbench/test_trt_timer_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_trt_timer_ctrl;
	import trt_pkg::*;
	logic clk = 1'b0, rstN = 1'b0, t0 = 1'b0, t1 = 1'b0, x0 = 1'b0, x1 = 1'b0;
	logic osc = 1'b0, ien = 1'b0, run0, run1, irq;
	trt_sfr_t sfr = '0;
	trt_vec_t vec = '0;
	logic [7:0] rdata, tctrl, v;
	logic [31:0] seed = 32'h00013a47;
	int error_cnt = 0, n_tests = 0;
	trt_timer_ctrl u_dut (.clk(clk), .rst_n(rstN), .sfr(sfr), .sfrRdata(rdata), .timer0Ovf(t0),
		.timer1Ovf(t1), .vecAck(vec), .extIrq0Input(x0), .extIrq1Input(x1), .extOscDiv8(osc),
		.reloadTimerIrqEn(ien), .timer0RunOut(run0), .timer1RunOut(run1), .tctrlOut(tctrl),
		.reloadTimerIrq(irq));
	initial forever #50 clk = ~clk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs
	// ext flags are left out: they follow events, not the written byte
	function automatic logic [7:0] expTc(input logic [7:0] d);
		return d & 8'hf5;
	endfunction : expTc
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic results;
		$display("errors=%0d tests=%0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr <= '{a, 1'b1, d};
		@(posedge clk);
		sfr.write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		sfr <= '{a, 1'b0, 8'h00};
		tick(1);
		v = rdata;
	endtask : rd
	// one-cycle event pulse: {t1, t0, vecAck}
	task automatic ev(input logic [5:0] e);
		@(posedge clk);
		{t1, t0, vec} <= e;
		@(posedge clk);
		{t1, t0, vec} <= '0;
		tick(1);
	endtask : ev
	initial begin
		#1000000;
		error_cnt++;
		results();
	end
	initial begin
		repeat (12) @(posedge clk);
		rstN <= 1'b1;
		rd(TRT_ADDR_TCTRL);
		chk(v, TRT_TCTRL_RST);
		rd(TRT_ADDR_RCTRL);
		chk(v, TRT_RCTRL_RST);
		repeat (8) begin
			seed = xs(seed);
			wr(TRT_ADDR_TCTRL, seed[7:0]);
			tick(1);
			chk(tctrl & 8'hf5, expTc(seed[7:0]));
			chk({6'h00, run1, run0}, {6'h00, seed[6], seed[4]});
		end
		wr(TRT_ADDR_TCTRL, 8'h00);
		ev(6'h30);
		chk(tctrl, 8'ha0);
		ev(6'h08);
		chk(tctrl, 8'h20);
		ev(6'h04);
		chk(tctrl, 8'h00);
		wr(TRT_ADDR_TCTRL, 8'h04);
		x1 <= 1'b1;
		tick(2);
		chk(tctrl, 8'h0c);
		ev(6'h02);
		chk(tctrl, 8'h04);
		x0 <= 1'b1;
		tick(2);
		ev(6'h01);
		chk(tctrl, 8'h06);
		// core clock for both halves so wrap timing is exact
		wr(TRT_ADDR_CKCFG, 8'hff);
		rd(TRT_ADDR_CKCFG);
		chk(v, CK_WRITE_MASK);
		wr(TRT_ADDR_RLL, 8'h34);
		wr(TRT_ADDR_RLH, 8'h12);
		wr(TRT_ADDR_CNTL, 8'hfe);
		wr(TRT_ADDR_CNTH, 8'hff);
		tick(5);
		rd(TRT_ADDR_CNTL);
		chk(v, 8'hfe);
		ien <= 1'b1;
		wr(TRT_ADDR_RCTRL, 8'h04);
		tick(6);
		chk({7'h00, irq}, 8'h01);
		rd(TRT_ADDR_CNTH);
		chk(v, 8'h12);
		rd(TRT_ADDR_RCTRL);
		chk(v, 8'hc4);
		wr(TRT_ADDR_RLL, 8'h80);
		wr(TRT_ADDR_RCTRL, 8'h00);
		wr(TRT_ADDR_CNTL, 8'hff);
		tick(1);
		chk({7'h00, irq}, 8'h00);
		wr(TRT_ADDR_RCTRL, 8'h28);
		rd(TRT_ADDR_CNTL);
		chk({7'h00, v >= 8'h80 && v <= 8'h82}, 8'h01);
		tick(1);
		chk({7'h00, irq}, 8'h01);
		rd(TRT_ADDR_CNTH);
		chk(v, 8'h12);
		rd(TRT_ADDR_RCTRL);
		chk(v, 8'h68);
		// chosen clock: divide by twelve, the read adds a cycle or two of slack
		wr(TRT_ADDR_CKCFG, 8'h00);
		wr(TRT_ADDR_CNTL, 8'h00);
		tick(120);
		rd(TRT_ADDR_CNTL);
		chk({7'h00, v >= 8'h09 && v <= 8'h0b}, 8'h01);
		wr(TRT_ADDR_RCTRL, 8'h09);
		wr(TRT_ADDR_CNTL, 8'h00);
		// five rising edges of the slow oscillator tick, driven on clock edges
		repeat (10) begin
			repeat (4) @(posedge clk);
			osc <= ~osc;
		end
		tick(5);
		rd(TRT_ADDR_CNTL);
		chk(v, 8'h05);
		results();
	end
endmodule : test_trt_timer_ctrl
`default_nettype wire

// *** testbench/trt_timer_ctrl_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module trt_timer_ctrl_properties (
	input wire logic clk, // core clock
	input wire logic rst_n, // async reset
	input wire trt_pkg::trt_sfr_t sfr, // register port
	input wire logic [7:0] sfrRdata, // read data
	input wire logic timer0Ovf, // timer zero overflow
	input wire logic timer1Ovf, // timer one overflow
	input wire trt_pkg::trt_vec_t vecAck, // vector pulses
	input wire logic extIrq0Input, // ext zero level
	input wire logic extIrq1Input, // ext one level
	input wire logic timer0RunOut, // run zero
	input wire logic timer1RunOut, // run one
	input wire logic [7:0] tctrlOut // control contents
);
	import trt_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic tw = sfr.write && sfr.addr == TRT_ADDR_TCTRL;
	a_t1_flag_set: assert property (timer1Ovf |=> tctrlOut[7])
		else $error("timer one flag missing");
	a_t0_flag_set: assert property (timer0Ovf |=> tctrlOut[5])
		else $error("timer zero flag missing");
	a_t0_vec_clear: assert property (vecAck.timer0 && !timer0Ovf && !tw |=> !tctrlOut[5])
		else $error("timer zero flag kept");
	a_run_out: assert property (timer1RunOut == tctrlOut[6] && timer0RunOut == tctrlOut[4])
		else $error("run outputs differ");
	a_x1_edge_set: assert property (tctrlOut[2] && extIrq1Input && !$past(extIrq1Input)
		|=> tctrlOut[3]) else $error("ext one edge lost");
	a_x0_level_set: assert property (!tctrlOut[0] && extIrq0Input |=> tctrlOut[1])
		else $error("ext zero level lost");
	a_rd_tctrl: assert property (sfr.addr == TRT_ADDR_TCTRL |=> sfrRdata == $past(tctrlOut))
		else $error("control readback wrong");
	a_tctrl_write: assert property (tw |=> (tctrlOut & 8'h55) == ($past(sfr.wdata) & 8'h55))
		else $error("control write lost");
endmodule : trt_timer_ctrl_properties
bind trt_timer_ctrl trt_timer_ctrl_properties u_props (.clk, .rst_n, .sfr, .sfrRdata, .timer0Ovf,
	.timer1Ovf, .vecAck, .extIrq0Input, .extIrq1Input, .timer0RunOut, .timer1RunOut, .tctrlOut);
`default_nettype wire
